// [sdram_seq_pkg.sv]
// Package with register map, field layout, reset values and sequencer states
//--------------------------------------------------------------------------------
//--------------------------------------------------------------------------------
package sdram_seq_pkg;

	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] CONFIG_OFFSET  = 8'h00;
	localparam logic [7:0] ADDRESS_OFFSET = 8'h04;
	localparam logic [7:0] WDATA_OFFSET   = 8'h08;
	localparam logic [7:0] COMMAND_OFFSET = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET  = 8'h10;
	localparam logic [7:0] RDATA_OFFSET   = 8'h14;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int ACT_WAIT_LSB   = 0;
	localparam int LATENCY_LSB    = 4;
	localparam int IDLE_COUNT_LSB = 8;
	localparam int STROBE_MODE    = 12;
	localparam int COL_LSB        = 0;
	localparam int ROW_LSB        = 10;
	localparam int BANK_LSB       = 23;
	localparam int BYTE_EN_LSB    = 16;
	localparam int CMD_START      = 0;
	localparam int CMD_WRITE      = 1;
	localparam int CMD_SOURCE_LSB = 2;
	localparam int CMD_PALL       = 4;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_DONE      = 1;
	localparam int STAT_READY     = 2;

	// --------------------------------------------------------------
	// Reset values and codes
	// --------------------------------------------------------------
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0023;
	localparam logic [1:0]  SRC_LOAD     = 2'h0;
	localparam logic [1:0]  SRC_FETCH    = 2'h1;
	localparam logic [1:0]  SRC_DMA      = 2'h2;

	typedef enum logic [3:0] {
		ST_PALL, ST_PALL_WAIT, ST_IDLE, ST_INTER, ST_PRE, ST_PRE_WAIT, ST_ACT, ST_ACT_WAIT,
		ST_ACCESS, ST_LATENCY, ST_BANK_PRE, ST_IDLE_STATE, ST_FINISH
	} seq_state_t;

	// Activation wait code to cycles; prohibited 00 treated as one wait
	function automatic logic [3:0] act_wait_cycles(input logic [1:0] code);
		act_wait_cycles = (code == 2'h0) ? 4'h1 : {2'h0, code};
	endfunction : act_wait_cycles

	// Latency code to cycles; prohibited codes treated as latency 1
	function automatic logic [3:0] latency_cycles(input logic [2:0] code);
		latency_cycles = (code == 3'h0 || code[2]) ? 4'h1 : {1'h0, code};
	endfunction : latency_cycles

endpackage : sdram_seq_pkg

// [bank_if.sv]
// Interface between the sequencer and the open-row tracker
`timescale 1ns/1ps
interface bank_if #(parameter int BANK_W = 2, parameter int ROW_W = 13);
	logic [BANK_W-1:0] bank;
	logic [ROW_W-1:0]  row;
	logic              target_open;
	logic              row_match;
	logic              last_open;
	logic [BANK_W-1:0] last_bank;
	logic              open_row;
	logic              close_bank;
	logic [BANK_W-1:0] close_id;
	logic              close_all;

	modport tracker (input bank, row, open_row, close_bank, close_id, close_all,
		output target_open, row_match, last_open, last_bank);
	modport seq (output bank, row, open_row, close_bank, close_id, close_all,
		input target_open, row_match, last_open, last_bank);
endinterface : bank_if

// [bank_tracker.sv]
// Open-row and last-bank tracker on the SDRAM clock
`timescale 1ns/1ps
module bank_tracker
	import sdram_seq_pkg::*;
#(
	parameter int BANK_W = 2,
	parameter int ROW_W  = 13
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	bank_if.tracker   bi
);
	localparam int BANKS = 1 << BANK_W;

	logic [BANKS-1:0] open_reg;
	logic [ROW_W-1:0] row_reg [BANKS];
	logic [BANK_W-1:0] last_bank_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_reg <= '0;
		end else if (ce) begin
			if (bi.close_all) begin
				open_reg <= '0;
			end else begin
				if (bi.close_bank) begin
					open_reg[bi.close_id] <= 1'b0;
				end
				if (bi.open_row) begin
					open_reg[bi.bank] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_bank_reg <= '0;
			for (int i = 0; i < BANKS; i++) begin
				row_reg[i] <= '0;
			end
		end else if (ce && bi.open_row) begin
			row_reg[bi.bank] <= bi.row;
			last_bank_reg    <= bi.bank;
		end
	end

	assign bi.target_open = open_reg[bi.bank];
	assign bi.row_match   = (row_reg[bi.bank] == bi.row);
	assign bi.last_open   = open_reg[last_bank_reg];
	assign bi.last_bank   = last_bank_reg;

endmodule : bank_tracker

// [sdram_access_sequencer.sv]
// SDRAM single read/write sequencer with APB registers and SDRAM-clock command logic
`timescale 1ns/1ps
module sdram_access_sequencer
	import sdram_seq_pkg::*;
#(
	parameter int BANK_W = 2,
	parameter int ROW_W  = 13,
	parameter int COL_W  = 10,
	parameter int DATA_W = 16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              sdram_clk,
	output logic                   sd_cs_n,
	output logic                   sd_ras_n,
	output logic                   sd_cas_n,
	output logic                   sd_we_n,
	output logic      [BANK_W-1:0] sd_ba,
	output logic      [ROW_W-1:0]  sd_addr,
	output logic      [DATA_W-1:0] sd_dq_out,
	output logic                   sd_dq_oe,
	input  wire logic [DATA_W-1:0] sd_dq_in,
	output logic      [1:0]        strobe_n,
	output logic                   bus_cycle_start_n
);
	// --------------------------------------------------------------
	// APB register file (pclk domain)
	// --------------------------------------------------------------
	logic [31:0] config_reg;
	logic [31:0] addr_reg;
	logic [17:0] wdata_reg;
	logic [4:0]  cmd_reg;
	logic [12:0] cmd_cfg_reg;
	logic        busy_reg;
	logic        done_reg;
	logic [15:0] rdata_reg;
	logic        req_tgl_reg;
	logic        ack_s1_reg, ack_s2_reg, ack_seen_reg;
	logic        rdy_s1_reg, rdy_s2_reg;
	logic        link_ack_tgl_reg;
	logic        link_ready_reg;
	logic [DATA_W-1:0] link_rdata_reg;

	logic wr_en;
	logic rd_en;
	logic mapped;
	logic accept;
	logic ack_event;

	assign wr_en     = psel && penable && pwrite && clk_en;
	assign rd_en     = psel && !pwrite;
	assign mapped    = (paddr == CONFIG_OFFSET) || (paddr == ADDRESS_OFFSET) || (paddr == WDATA_OFFSET)
		|| (paddr == COMMAND_OFFSET) || (paddr == STATUS_OFFSET) || (paddr == RDATA_OFFSET);
	assign accept    = wr_en && (paddr == COMMAND_OFFSET) && pwdata[CMD_START] && !busy_reg;
	assign ack_event = ack_s2_reg != ack_seen_reg;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;

	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				CONFIG_OFFSET:  prdata = config_reg;
				ADDRESS_OFFSET: prdata = addr_reg;
				WDATA_OFFSET:   prdata = {14'h0000, wdata_reg};
				COMMAND_OFFSET: prdata = {27'h000_0000, cmd_reg};
				STATUS_OFFSET:  prdata = {29'h0000_0000, rdy_s2_reg, done_reg, busy_reg};
				RDATA_OFFSET:   prdata = {16'h0000, rdata_reg};
				default:        prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_reg <= CONFIG_RESET;
			addr_reg   <= 32'h0000_0000;
			wdata_reg  <= 18'h0_0000;
		end else if (wr_en) begin
			case (paddr)
				CONFIG_OFFSET:  config_reg <= {19'h0_0000, pwdata[12:0]};
				ADDRESS_OFFSET: addr_reg <= {7'h00, pwdata[24:0]};
				WDATA_OFFSET:   wdata_reg <= pwdata[17:0];
				default:        ;
			endcase
		end
	end

	// Request words stay frozen from accept until the acknowledge returns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg     <= 5'h00;
			cmd_cfg_reg <= 13'h0000;
			req_tgl_reg <= 1'b0;
		end else if (accept) begin
			cmd_reg     <= pwdata[4:0];
			cmd_cfg_reg <= config_reg[12:0];
			req_tgl_reg <= !req_tgl_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_s1_reg   <= 1'b0;
			ack_s2_reg   <= 1'b0;
			ack_seen_reg <= 1'b0;
			rdy_s1_reg   <= 1'b0;
			rdy_s2_reg   <= 1'b0;
		end else if (clk_en) begin
			ack_s1_reg   <= link_ack_tgl_reg;
			ack_s2_reg   <= ack_s1_reg;
			ack_seen_reg <= ack_s2_reg;
			rdy_s1_reg   <= link_ready_reg;
			rdy_s2_reg   <= rdy_s1_reg;
		end
	end

	// Completion sets done, which wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
			rdata_reg <= 16'h0000;
		end else if (clk_en) begin
			if (accept) begin
				busy_reg <= 1'b1;
			end else if (ack_event) begin
				busy_reg <= 1'b0;
			end
			if (ack_event) begin
				done_reg  <= 1'b1;
				rdata_reg <= 16'(link_rdata_reg);
			end else if (wr_en && paddr == STATUS_OFFSET && pwdata[STAT_DONE]) begin
				done_reg <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Link domain reset, enable and request synchronisers
	// --------------------------------------------------------------
	logic link_rst_s1_reg, link_rst_n;
	logic ce_s1_reg, link_ce;
	logic req_s1_reg, req_s2_reg, req_taken_reg;

	always_ff @(posedge sdram_clk or negedge presetn) begin
		if (!presetn) begin
			link_rst_s1_reg <= 1'b0;
			link_rst_n      <= 1'b0;
		end else begin
			link_rst_s1_reg <= 1'b1;
			link_rst_n      <= link_rst_s1_reg;
		end
	end

	always_ff @(posedge sdram_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ce_s1_reg  <= 1'b0;
			link_ce    <= 1'b0;
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
		end else begin
			ce_s1_reg  <= clk_en;
			link_ce    <= ce_s1_reg;
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
		end
	end

	// --------------------------------------------------------------
	// Command sequencer (SDRAM clock domain)
	// --------------------------------------------------------------
	seq_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic       pending;
	logic       is_write;
	logic       cpu_read;
	logic       decide;
	logic       bank_change_reg;
	logic [BANK_W-1:0] prev_bank_reg;
	logic [3:0] act_wait;
	logic [3:0] latency;
	seq_state_t first_cmd;
	seq_state_t after_access;

	bank_if #(.BANK_W(BANK_W), .ROW_W(ROW_W)) bi ();

	bank_tracker #(.BANK_W(BANK_W), .ROW_W(ROW_W)) u_tracker (
		.clk   (sdram_clk),
		.rst_n (link_rst_n),
		.ce    (link_ce),
		.bi    (bi)
	);

	assign pending  = req_s2_reg != req_taken_reg;
	assign is_write = cmd_reg[CMD_WRITE];
	assign cpu_read = !is_write && (cmd_reg[CMD_SOURCE_LSB +: 2] != SRC_DMA);
	assign act_wait = act_wait_cycles(cmd_cfg_reg[ACT_WAIT_LSB +: 2]);
	assign latency  = latency_cycles(cmd_cfg_reg[LATENCY_LSB +: 3]);
	assign decide   = (state_reg == ST_INTER)
		|| (state_reg == ST_IDLE && pending && link_ready_reg && !cmd_reg[CMD_PALL] && !cpu_read);

	assign bi.bank       = addr_reg[BANK_LSB +: BANK_W];
	assign bi.row        = addr_reg[ROW_LSB +: ROW_W];
	assign bi.open_row   = link_ce && (state_reg == ST_ACT);
	assign bi.close_bank = link_ce && (state_reg == ST_PRE || state_reg == ST_BANK_PRE);
	assign bi.close_id   = (state_reg == ST_BANK_PRE) ? prev_bank_reg : bi.bank;
	assign bi.close_all  = link_ce && (state_reg == ST_PALL);

	// Classify: on-page goes straight to the access, page change to PRE, closed bank to ACT
	always_comb begin
		if (bi.target_open && bi.row_match) begin
			first_cmd = ST_ACCESS;
		end else if (bi.target_open) begin
			first_cmd = ST_PRE;
		end else begin
			first_cmd = ST_ACT;
		end
	end

	always_comb begin
		if (bank_change_reg) begin
			after_access = ST_BANK_PRE;
		end else if (!is_write && cmd_cfg_reg[IDLE_COUNT_LSB +: 2] != 2'h0) begin
			after_access = ST_IDLE_STATE;
		end else begin
			after_access = ST_FINISH;
		end
	end

	// Waits come only from the configuration counts, never from a wait pin
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_PALL: begin
				state_next = ST_PALL_WAIT;
				cnt_next   = act_wait;
			end
			ST_PALL_WAIT, ST_PRE_WAIT, ST_ACT_WAIT, ST_IDLE_STATE: begin
				if (cnt_reg > 4'h1) begin
					cnt_next = cnt_reg - 4'h1;
				end else if (state_reg == ST_PALL_WAIT) begin
					state_next = ST_IDLE;
				end else if (state_reg == ST_PRE_WAIT) begin
					state_next = ST_ACT;
				end else if (state_reg == ST_ACT_WAIT) begin
					state_next = ST_ACCESS;
				end else begin
					state_next = ST_FINISH;
				end
			end
			ST_IDLE: begin
				if (!link_ready_reg || (pending && cmd_reg[CMD_PALL])) begin
					state_next = ST_PALL;
				end else if (pending && cpu_read) begin
					state_next = ST_INTER;
				end else if (pending) begin
					state_next = first_cmd;
				end
			end
			ST_INTER: state_next = first_cmd;
			ST_PRE: begin
				state_next = ST_PRE_WAIT;
				cnt_next   = act_wait;
			end
			ST_ACT: begin
				state_next = ST_ACT_WAIT;
				cnt_next   = act_wait;
			end
			ST_ACCESS: begin
				if (is_write) begin
					state_next = after_access;
				end else begin
					state_next = ST_LATENCY;
					cnt_next   = latency;
				end
			end
			ST_LATENCY: begin
				if (cnt_reg > 4'h1) begin
					cnt_next = cnt_reg - 4'h1;
				end else begin
					state_next = after_access;
					cnt_next   = {2'h0, cmd_cfg_reg[IDLE_COUNT_LSB +: 2]};
				end
			end
			ST_BANK_PRE: begin
				if (!is_write && cmd_cfg_reg[IDLE_COUNT_LSB +: 2] != 2'h0) begin
					state_next = ST_IDLE_STATE;
					cnt_next   = {2'h0, cmd_cfg_reg[IDLE_COUNT_LSB +: 2]};
				end else begin
					state_next = ST_FINISH;
				end
			end
			ST_FINISH: state_next = ST_IDLE;
			default:   state_next = ST_IDLE;
		endcase
	end

	// Leaving reset runs a precharge-all before any access
	always_ff @(posedge sdram_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
		end else if (link_ce) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge sdram_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			req_taken_reg    <= 1'b0;
			link_ack_tgl_reg <= 1'b0;
			link_ready_reg   <= 1'b0;
			bank_change_reg  <= 1'b0;
			prev_bank_reg    <= '0;
		end else if (link_ce) begin
			if (state_reg == ST_IDLE && pending && link_ready_reg) begin
				req_taken_reg <= req_s2_reg;
			end
			if (state_reg == ST_FINISH || (state_reg == ST_PALL_WAIT && state_next == ST_IDLE && link_ready_reg)) begin
				link_ack_tgl_reg <= !link_ack_tgl_reg;
			end
			if (state_reg == ST_PALL_WAIT && state_next == ST_IDLE) begin
				link_ready_reg <= 1'b1;
			end
			if (decide) begin
				bank_change_reg <= bi.last_open && (bi.last_bank != bi.bank);
				prev_bank_reg   <= bi.last_bank;
			end
		end
	end

	always_ff @(posedge sdram_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_rdata_reg <= '0;
		end else if (link_ce && state_reg == ST_LATENCY && cnt_reg == 4'h1) begin
			link_rdata_reg <= sd_dq_in;
		end
	end

	// --------------------------------------------------------------
	// SDRAM pins, registered from the next state; bus_cycle_start_n registered from decide in the current state
	// --------------------------------------------------------------
	always_ff @(posedge sdram_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			{sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= 4'hF;
			sd_ba             <= '0;
			sd_addr           <= '0;
			sd_dq_out         <= '0;
			sd_dq_oe          <= 1'b0;
			strobe_n          <= 2'h3;
			bus_cycle_start_n <= 1'b1;
		end else if (link_ce) begin
			{sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= 4'hF;
			sd_ba             <= bi.bank;
			sd_addr           <= '0;
			sd_dq_oe          <= 1'b0;
			strobe_n          <= 2'h3;
			bus_cycle_start_n <= !decide;
			case (state_next)
				ST_PALL: begin
					{sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= 4'h2;
					sd_addr[10] <= 1'b1;
				end
				ST_PRE, ST_BANK_PRE: begin
					{sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= 4'h2;
					sd_ba <= (state_next == ST_BANK_PRE) ? prev_bank_reg : bi.bank;
				end
				ST_ACT: begin
					{sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= 4'h3;
					sd_addr <= bi.row;
				end
				ST_ACCESS: begin
					{sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= {3'h2, !is_write};
					sd_addr   <= ROW_W'(addr_reg[COL_LSB +: COL_W]);
					sd_dq_out <= DATA_W'(wdata_reg[15:0]);
					sd_dq_oe  <= is_write;
				end
				default: ;
			endcase
			if (state_next == ST_ACCESS || state_next == ST_LATENCY) begin
				if (cmd_cfg_reg[STROBE_MODE] || is_write) begin
					strobe_n <= ~wdata_reg[BYTE_EN_LSB +: 2];
				end else begin
					strobe_n <= 2'h0;
				end
			end
		end
	end

endmodule : sdram_access_sequencer

// [sdram_access_sequencer_asserts.sv]
// Assertion checker on the sequencer's top-level ports
`timescale 1ns/1ps
module sdram_access_sequencer_asserts
	import sdram_seq_pkg::*;
#(
	parameter int BANK_W = 2,
	parameter int ROW_W  = 13
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              sdram_clk,
	input wire logic              sd_cs_n,
	input wire logic              sd_ras_n,
	input wire logic              sd_cas_n,
	input wire logic              sd_we_n,
	input wire logic [BANK_W-1:0] sd_ba,
	input wire logic [ROW_W-1:0]  sd_addr,
	input wire logic              sd_dq_oe,
	input wire logic [1:0]        strobe_n,
	input wire logic              bus_cycle_start_n
);
	// ----------------------
	// Shadow state
	// ----------------------
	logic [31:0]       cfg_reg;
	logic [1:0]        be_reg;
	logic [3:0]        prev_cmd_reg;
	logic [3:0]        gap_reg;
	logic [BANK_W-1:0] prev_ba_reg;
	logic              prev_a10_reg;
	logic              prev_first_reg;
	logic              seen_reg;
	wire logic [3:0]   cmd    = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
	wire logic         is_cmd = !sd_cs_n && cmd[2:0] != 3'h7;
	wire logic [3:0]   aw     = (cfg_reg[1:0] == 2'h0) ? 4'h1 : {2'h0, cfg_reg[1:0]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= CONFIG_RESET;
			be_reg  <= 2'h0;
		end else if (psel && penable && pwrite) begin
			if (paddr == CONFIG_OFFSET) cfg_reg <= pwdata;
			if (paddr == WDATA_OFFSET) be_reg <= pwdata[17:16];
		end
	end

	// Last command on the pins and NOP cycles since it
	always_ff @(posedge sdram_clk or negedge presetn) begin
		if (!presetn) begin
			prev_cmd_reg   <= 4'hF;
			prev_ba_reg    <= '0;
			prev_a10_reg   <= 1'b0;
			prev_first_reg <= 1'b0;
			gap_reg        <= 4'h0;
			seen_reg       <= 1'b0;
		end else if (is_cmd) begin
			prev_cmd_reg   <= cmd;
			prev_ba_reg    <= sd_ba;
			prev_a10_reg   <= sd_addr[10];
			prev_first_reg <= !bus_cycle_start_n;
			gap_reg        <= 4'h0;
			seen_reg       <= 1'b1;
		end else if (gap_reg != 4'hF) begin
			gap_reg <= gap_reg + 4'h1;
		end
	end

	// ----------------------
	// Assertions
	// ----------------------
	AST_PALL_FIRST: assert property (@(posedge sdram_clk) disable iff (!presetn)
		is_cmd && !seen_reg |-> cmd == 4'h2 && sd_addr[10])
		else $error("first command is not precharge-all");
	AST_NO_ACCESS_AFTER_PALL: assert property (@(posedge sdram_clk) disable iff (!presetn)
		is_cmd && cmd[3:1] == 3'h2 |-> !(prev_cmd_reg == 4'h2 && prev_a10_reg))
		else $error("access right after precharge-all");
	AST_ACT_TO_ACCESS: assert property (@(posedge sdram_clk) disable iff (!presetn)
		cmd[3:1] == 3'h2 && prev_cmd_reg == 4'h3 |-> gap_reg == aw)
		else $error("wrong wait count after activate");
	AST_PRE_TO_ACT: assert property (@(posedge sdram_clk) disable iff (!presetn)
		cmd == 4'h3 && prev_cmd_reg == 4'h2 && prev_first_reg && !prev_a10_reg |-> gap_reg == aw)
		else $error("wrong wait count after precharge");
	AST_BANK_PRE: assert property (@(posedge sdram_clk) disable iff (!presetn)
		cmd == 4'h2 && !sd_addr[10] && bus_cycle_start_n |-> prev_cmd_reg[3:1] == 3'h2 && sd_ba != prev_ba_reg)
		else $error("trailing precharge not after access to other bank");
	AST_WRITE_DRIVE: assert property (@(posedge sdram_clk) disable iff (!presetn)
		sd_dq_oe == (cmd == 4'h4))
		else $error("data drive not aligned with write command");
	AST_STROBE_WR: assert property (@(posedge sdram_clk) disable iff (!presetn)
		cmd == 4'h4 |-> strobe_n == ~be_reg)
		else $error("strobe pins wrong on write");
	AST_STROBE_RD: assert property (@(posedge sdram_clk) disable iff (!presetn)
		cmd == 4'h5 |-> strobe_n == (cfg_reg[STROBE_MODE] ? ~be_reg : 2'h0))
		else $error("strobe pins wrong on read");
	AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && paddr > RDATA_OFFSET |-> pslverr && pready)
		else $error("unmapped access not flagged");
endmodule : sdram_access_sequencer_asserts

// [sdram_device_model.sv]
// Behavioural SDRAM device on the far side of the sequencer
`timescale 1ns/1ps
module sdram_device_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  cmd,
	input  wire logic [1:0]  ba,
	input  wire logic [12:0] addr,
	input  wire logic [15:0] dq_out,
	input  wire logic [1:0]  strobe_n,
	input  wire logic [1:0]  lat,
	output logic      [15:0] dq_in,
	output logic      [7:0]  bad_cmds
);
	logic [15:0] mem [logic [24:0]];
	logic [12:0] row_reg [4];
	logic [3:0]  open_reg;
	logic [1:0]  cnt_reg;
	logic [15:0] rd_reg = 16'h0;
	logic [24:0] key;
	logic [15:0] old;

	// Data valid only in the cycle before the latency edge, inverted otherwise
	assign dq_in = (cnt_reg == 2'h1) ? rd_reg : ~rd_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_reg <= 4'h0;
			cnt_reg  <= 2'h0;
			bad_cmds <= 8'h0;
		end else begin
			if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
			case (cmd)
				4'h2: open_reg <= addr[10] ? 4'h0 : open_reg & ~(4'h1 << ba);
				4'h3: begin
					if (open_reg[ba]) bad_cmds <= bad_cmds + 8'h1;
					open_reg[ba] <= 1'b1;
					row_reg[ba]  <= addr;
				end
				4'h4, 4'h5: begin
					if (!open_reg[ba]) bad_cmds <= bad_cmds + 8'h1;
					key = {ba, row_reg[ba], addr[9:0]};
					old = mem.exists(key) ? mem[key] : 16'h0;
					if (cmd[0]) begin
						rd_reg  <= old;
						cnt_reg <= lat;
					end else begin
						mem[key] = {strobe_n[1] ? old[15:8] : dq_out[15:8], strobe_n[0] ? old[7:0] : dq_out[7:0]};
					end
				end
				default: ;
			endcase
		end
	end
endmodule : sdram_device_model

// [sdram_access_sequencer_tb_top.sv]
// Self-checking bench for the SDRAM access sequencer
`timescale 1ns/1ps
module sdram_access_sequencer_tb_top
	import sdram_seq_pkg::*;
();
	logic        pclk = 1'b0, sdram_clk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, note_rd = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, r;
	logic        pready, pslverr, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe, bus_cycle_start_n;
	logic [1:0]  sd_ba, strobe_n, ob, lat = 2'h2;
	logic [12:0] sd_addr, orow;
	logic [15:0] sd_dq_out, sd_dq_in;
	logic [7:0]  bad_cmds;
	logic [18:0] cq [$];
	logic [32:0] rq [$];
	logic [15:0] mirror [logic [24:0]];
	logic        ov = 1'b0;
	int          miscompares = 0, total_checks = 0, cycles = 0, seed = 32'h5b49;

	initial forever #5 pclk = ~pclk;
	initial begin
		#7;
		forever #32 sdram_clk = ~sdram_clk;
	end

	sdram_access_sequencer u_sdram_access_sequencer (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sdram_clk(sdram_clk), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
		.sd_we_n(sd_we_n), .sd_ba(sd_ba), .sd_addr(sd_addr), .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe),
		.sd_dq_in(sd_dq_in), .strobe_n(strobe_n), .bus_cycle_start_n(bus_cycle_start_n));
	sdram_device_model u_sdram_device_model (.clk(sdram_clk), .rst_n(presetn),
		.cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}), .ba(sd_ba), .addr(sd_addr), .dq_out(sd_dq_out),
		.strobe_n(strobe_n), .lat(lat), .dq_in(sd_dq_in), .bad_cmds(bad_cmds));

	// ----------------------
	// Checking and bus tasks
	// ----------------------
	task automatic cmp_reg(input logic [32:0] e, input logic [32:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask : cmp_reg
	task automatic cmp_cmd(input logic [18:0] e, input logic [18:0] g);
		cmp_reg({14'h0, e}, {14'h0, g});
	endtask : cmp_cmd
	task automatic end_of_test();
		$display("total_checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			end_of_test();
		end
	end

	always @(posedge sdram_clk) begin : cmd_mon
		logic [3:0] c;
		c = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
		if (presetn && !c[3] && c[2:0] != 3'h7)
			cmp_cmd(cq.size() != 0 ? cq.pop_front() : 19'h7FFFF, {c, (c == 4'h2 && sd_addr[10]) ? 2'h0 : sd_ba,
				c == 4'h3 ? sd_addr : (c == 4'h2 ? {2'h0, sd_addr[10], 10'h0} : {3'h0, sd_addr[9:0]})});
	end
	always @(posedge pclk)
		if (psel && penable && pready && note_rd)
			cmp_reg(rq.pop_front(), {pslverr, prdata});

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic chk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		note_rd <= chk;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0, 1'b1);
	endtask : rd_chk
	task automatic note(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
		cq.push_back({c, b, a});
	endtask : note
	task automatic cmd_run(input logic [31:0] c, input logic dup);
		apb(1'b1, COMMAND_OFFSET, c, 1'b0);
		if (dup) apb(1'b1, COMMAND_OFFSET, c, 1'b0);
		q = 32'h0;
		repeat (300) if (!q[STAT_DONE]) apb(1'b0, STATUS_OFFSET, 32'h0, 1'b0);
		cmp_reg(33'h1, {32'h0, q[STAT_DONE]});
		apb(1'b1, STATUS_OFFSET, 32'h2, 1'b0);
	endtask : cmd_run
	// Expected pin sequence from this bench's own open-row bookkeeping
	task automatic access(input logic w, input logic [1:0] src, input logic [24:0] k, input logic [17:0] wd,
			input logic dup);
		logic [15:0] old;
		old = mirror.exists(k) ? mirror[k] : 16'h0;
		if (!(ov && ob == k[24:23] && orow == k[22:10])) begin
			if (ov && ob == k[24:23]) note(4'h2, ob, 13'h0);
			note(4'h3, k[24:23], k[22:10]);
		end
		note({3'h2, !w}, k[24:23], {3'h0, k[9:0]});
		if (ov && ob != k[24:23]) note(4'h2, ob, 13'h0);
		ov   = 1'b1;
		ob   = k[24:23];
		orow = k[22:10];
		if (w) mirror[k] = {wd[17] ? wd[15:8] : old[15:8], wd[16] ? wd[7:0] : old[7:0]};
		apb(1'b1, ADDRESS_OFFSET, {7'h0, k}, 1'b0);
		apb(1'b1, WDATA_OFFSET, {14'h0, wd}, 1'b0);
		cmd_run({27'h0, 1'b0, src, w, 1'b1}, dup);
		if (!w) rd_chk(RDATA_OFFSET, {17'h0, old});
	endtask : access

	// ----------------------
	// Main sequence
	// ----------------------
	initial begin
		note(4'h2, 2'h0, 13'h0400);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, 8'h18, 32'hFFFF, 1'b0);
		rd_chk(CONFIG_OFFSET, {1'b0, CONFIG_RESET});
		rd_chk(8'h18, {1'b1, 32'h0});
		for (int i = 0; i < 18; i++) begin
			r = $random(seed);
			lat <= 2'(i % 3 + 1);
			apb(1'b1, CONFIG_OFFSET, {19'h0, i[0], 2'h0, 2'(i % 3 + 1), 1'b0, 3'(i % 3 + 1), 2'h0,
				2'(i / 3 % 3 + 1)}, 1'b0);
			access(1'b1, i[0] ? SRC_DMA : SRC_LOAD, {i[3], r[1], r[2] ? 13'h1ABC : 13'h0155, r[15:6]},
				r[31:14], 1'b0);
			access(1'b0, 2'(i % 3), {i[3], r[1], r[2] ? 13'h1ABC : 13'h0155, r[15:6]},
				r[31:14], 1'b0);
		end
		note(4'h2, 2'h0, 13'h0400);
		cmd_run(32'h11, 1'b0);
		ov = 1'b0;
		access(1'b0, SRC_LOAD, {1'b1, r[1], r[2] ? 13'h1ABC : 13'h0155, r[15:6]}, r[31:14], 1'b1);
		repeat (40) @(posedge pclk);
		cmp_reg(33'h0, 33'(cq.size()));
		cmp_reg(33'h0, {25'h0, bad_cmds});
		end_of_test();
	end
endmodule : sdram_access_sequencer_tb_top

bind sdram_access_sequencer sdram_access_sequencer_asserts #(.BANK_W(BANK_W), .ROW_W(ROW_W))
	u_sdram_access_sequencer_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sdram_clk(sdram_clk),
	.sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_ba(sd_ba),
	.sd_addr(sd_addr), .sd_dq_oe(sd_dq_oe), .strobe_n(strobe_n), .bus_cycle_start_n(bus_cycle_start_n));
